// file: shared/tacl_cfg.svh
// constants for the touch converter configuration and temperature limit bank
// assumes a 10 MHz clock and 16-bit register words at byte-free offsets
`ifndef TACL_CFG_SVH
`define TACL_CFG_SVH

`define TACL_OFF_RESET      8'h04
`define TACL_OFF_CONFIG     8'h05
`define TACL_OFF_UPPER      8'h06
`define TACL_OFF_LOWER      8'h07

`define TACL_RESET_ALL_CODE 16'hbb00
`define TACL_RST_RESET      16'hffff
`define TACL_RST_CONFIG     7'h00
`define TACL_RST_UPPER      13'h0fff
`define TACL_RST_LOWER      13'h0000

`define TACL_PD_BIT         6
`define TACL_PRE_MSB        5
`define TACL_PRE_LSB        3
`define TACL_CFG_MSB        6
`define TACL_EN_BIT         12
`define TACL_LIM_MSB        11

`define TACL_SCAN_TEMP_FIRST  4'h6
`define TACL_SCAN_TEMP_SECOND 4'h7

`define TACL_CLK_NS         100
`define TACL_PRE_T000_NS    20000
`define TACL_PRE_T001_NS    84000
`define TACL_PRE_T010_NS    276000
`define TACL_PRE_T011_NS    340000
`define TACL_PRE_T100_NS    1044000
`define TACL_PRE_T101_NS    1108000
`define TACL_PRE_T111_NS    1364000
`define TACL_CYC(t)         (((t) + `TACL_CLK_NS - 1) / `TACL_CLK_NS)

`endif

// file: shared/tacl_pkg.sv
// types used by the precharge timer of the touch configuration bank
// assumes tacl_cfg.svh supplies all numeric constants
`default_nettype none
package tacl_pkg;
  typedef enum logic [0:0] {
    TACL_PRE_IDLE = 1'b0,
    TACL_PRE_RUN  = 1'b1
  } tacl_pre_state_e;
  typedef logic [13:0] tacl_cnt_t;
endpackage
`default_nettype wire

// file: src/tacl_precharge.sv
// precharge interval timer ahead of a touch sense
// assumes a synchronous start pulse and the synchronised reset copy
`timescale 1ns/100ps
`default_nettype none
`include "tacl_cfg.svh"
module tacl_precharge #(
  parameter int CYC_100 = `TACL_CYC(`TACL_PRE_T100_NS),
  parameter int CYC_101 = `TACL_CYC(`TACL_PRE_T101_NS),
  parameter int CYC_111 = `TACL_CYC(`TACL_PRE_T111_NS)
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n_sync,
  // control
  input  wire logic       start,
  input  wire logic       powerdown,
  input  wire logic [2:0] sel,
  // status
  output logic            active,
  output logic            done
);
  tacl_pkg::tacl_pre_state_e state;
  tacl_pkg::tacl_pre_state_e next_state;
  tacl_pkg::tacl_cnt_t       cnt;
  tacl_pkg::tacl_cnt_t       next_cnt;
  tacl_pkg::tacl_cnt_t       load;
  logic                      next_done;
  logic                      go;

  assign go     = start && !powerdown && (state == tacl_pkg::TACL_PRE_IDLE);
  assign active = (state == tacl_pkg::TACL_PRE_RUN);

  always_comb begin
    unique case (sel)
      3'h0: load = 14'(`TACL_CYC(`TACL_PRE_T000_NS) - 1);
      3'h1: load = 14'(`TACL_CYC(`TACL_PRE_T001_NS) - 1);
      3'h2: load = 14'(`TACL_CYC(`TACL_PRE_T010_NS) - 1);
      3'h3: load = 14'(`TACL_CYC(`TACL_PRE_T011_NS) - 1);
      3'h4: load = 14'(CYC_100 - 1);
      3'h5: load = 14'(CYC_101 - 1);
      // unlisted code reuses the longest interval
      3'h6: load = 14'(CYC_111 - 1);
      3'h7: load = 14'(CYC_111 - 1);
    endcase
  end

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_done  = 1'b0;
    unique case (state)
      tacl_pkg::TACL_PRE_IDLE: begin
        if (go) begin
          next_state = tacl_pkg::TACL_PRE_RUN;
          next_cnt   = load;
        end
      end
      tacl_pkg::TACL_PRE_RUN: begin
        // powerdown abandons the sense at once
        if (powerdown) begin
          next_state = tacl_pkg::TACL_PRE_IDLE;
        end else if (cnt == 14'h0000) begin
          next_state = tacl_pkg::TACL_PRE_IDLE;
          next_done  = 1'b1;
        end else begin
          next_cnt = cnt - 14'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state <= tacl_pkg::TACL_PRE_IDLE;
      cnt   <= 14'h0000;
      done  <= 1'b0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      done  <= next_done;
    end
  end

  pre_short_a: assert property (
    @(posedge clock) disable iff (!rst_n_sync)
    go && sel == 3'h0
    |=> active && cnt == 14'(`TACL_CYC(`TACL_PRE_T000_NS) - 1))
    else $error("precharge 000 loaded wrong count");
  pre_code6_a: assert property (
    @(posedge clock) disable iff (!rst_n_sync)
    go && sel == 3'h6 |=> active && cnt == 14'(CYC_111 - 1))
    else $error("precharge 110 not fixed interval");
  pre_pd_a: assert property (
    @(posedge clock) disable iff (!rst_n_sync)
    powerdown |=> !active && !$rose(done))
    else $error("precharge ran while pen detect powered down");
  pre_done_c: cover property (@(posedge clock) disable iff (!rst_n_sync)
    done);
endmodule
`default_nettype wire

// file: src/tacl_regs.sv
// touch configuration and temperature limit register bank
// assumes the serial port delivers decoded word writes and read requests
// on this clock, and that conversion results arrive on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "tacl_cfg.svh"
module tacl_regs #(
  parameter int CYC_100 = `TACL_CYC(`TACL_PRE_T100_NS),
  parameter int CYC_101 = `TACL_CYC(`TACL_PRE_T101_NS),
  parameter int CYC_111 = `TACL_CYC(`TACL_PRE_T111_NS)
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // measurement context
  input  wire logic        auto_scan,
  input  wire logic        auto_temp_sensor_select,
  input  wire logic [3:0]  converter_scan_mode_field,
  // conversion results
  input  wire logic        conv_valid,
  input  wire logic        conv_is_temp,
  input  wire logic        conv_sensor,
  input  wire logic [11:0] conv_data,
  // touch sense
  input  wire logic        sense_start,
  output logic             precharge_active,
  output logic             precharge_done,
  output logic             pen_detect_en,
  // limit events
  output logic             temp_upper_hit,
  output logic             temp_lower_hit,
  output logic             temp_irq
);
  logic        rst_meta;
  logic        rst_n_sync;
  logic [15:0] reset_command;
  logic [6:0]  touch_sense_config;
  logic [12:0] temp_upper_limit;
  logic [12:0] temp_lower_limit;
  logic [15:0] next_reset_command;
  logic [6:0]  next_touch_sense_config;
  logic [12:0] next_temp_upper_limit;
  logic [12:0] next_temp_lower_limit;
  logic [15:0] next_rdata;
  logic        next_upper_hit;
  logic        next_lower_hit;
  logic        soft_reset;
  logic        sensor_sel;
  logic        check_ok;
  logic        pen_detect_powerdown;
  logic [2:0]  precharge_time_sel;
  logic        temp_upper_check_en;
  logic        temp_lower_check_en;
  logic [11:0] temp_upper_limit_val;
  logic [11:0] temp_lower_limit_val;

  // reset released through two flops, asserted at once
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta   <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_n_sync <= rst_meta;
    end
  end

  assign pen_detect_powerdown = touch_sense_config[`TACL_PD_BIT];
  assign precharge_time_sel   =
    touch_sense_config[`TACL_PRE_MSB:`TACL_PRE_LSB];
  assign temp_upper_check_en  = temp_upper_limit[`TACL_EN_BIT];
  assign temp_lower_check_en  = temp_lower_limit[`TACL_EN_BIT];
  assign temp_upper_limit_val = temp_upper_limit[`TACL_LIM_MSB:0];
  assign temp_lower_limit_val = temp_lower_limit[`TACL_LIM_MSB:0];
  assign pen_detect_en        = !pen_detect_powerdown;

  // other codes are simply stored; the host must not send them
  assign soft_reset = reg_wr && reg_addr == `TACL_OFF_RESET
                      && reg_wdata == `TACL_RESET_ALL_CODE;

  always_comb begin
    next_reset_command      = reset_command;
    next_touch_sense_config = touch_sense_config;
    next_temp_upper_limit   = temp_upper_limit;
    next_temp_lower_limit   = temp_lower_limit;
    if (soft_reset) begin
      // reset-all returns every control register to power-up
      next_reset_command      = `TACL_RST_RESET;
      next_touch_sense_config = `TACL_RST_CONFIG;
      next_temp_upper_limit   = `TACL_RST_UPPER;
      next_temp_lower_limit   = `TACL_RST_LOWER;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `TACL_OFF_RESET:  next_reset_command = reg_wdata;
        `TACL_OFF_CONFIG:
          next_touch_sense_config = reg_wdata[`TACL_CFG_MSB:0];
        `TACL_OFF_UPPER:
          next_temp_upper_limit = reg_wdata[`TACL_EN_BIT:0];
        `TACL_OFF_LOWER:
          next_temp_lower_limit = reg_wdata[`TACL_EN_BIT:0];
        default: ;
      endcase
    end
  end

  // reserved bits read zero; unmapped offsets read zero
  always_comb begin
    next_rdata = reg_rdata;
    if (reg_rd) begin
      unique case (reg_addr)
        `TACL_OFF_RESET:  next_rdata = reset_command;
        `TACL_OFF_CONFIG: next_rdata = {9'h000, touch_sense_config};
        `TACL_OFF_UPPER:  next_rdata = {3'h0, temp_upper_limit};
        `TACL_OFF_LOWER:  next_rdata = {3'h0, temp_lower_limit};
        default:          next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      reset_command      <= `TACL_RST_RESET;
      touch_sense_config <= `TACL_RST_CONFIG;
      temp_upper_limit   <= `TACL_RST_UPPER;
      temp_lower_limit   <= `TACL_RST_LOWER;
      reg_rdata          <= 16'h0000;
    end else begin
      reset_command      <= next_reset_command;
      touch_sense_config <= next_touch_sense_config;
      temp_upper_limit   <= next_temp_upper_limit;
      temp_lower_limit   <= next_temp_lower_limit;
      reg_rdata          <= next_rdata;
    end
  end

  // sensor under check: auto mode follows the select bit
  always_comb begin
    sensor_sel = auto_temp_sensor_select;
    check_ok   = 1'b0;
    if (auto_scan) begin
      check_ok = 1'b1;
    end else if (converter_scan_mode_field == `TACL_SCAN_TEMP_FIRST) begin
      sensor_sel = 1'b0;
      check_ok   = 1'b1;
    end else if (converter_scan_mode_field == `TACL_SCAN_TEMP_SECOND) begin
      sensor_sel = 1'b1;
      check_ok   = 1'b1;
    end
  end

  always_comb begin
    next_upper_hit = 1'b0;
    next_lower_hit = 1'b0;
    // only temperature results on the chosen sensor count
    if (conv_valid && conv_is_temp && check_ok
        && conv_sensor == sensor_sel) begin
      next_upper_hit = temp_upper_check_en
                       && conv_data >= temp_upper_limit_val;
      next_lower_hit = temp_lower_check_en
                       && conv_data <= temp_lower_limit_val;
    end
  end

  always_ff @(posedge clock or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      temp_upper_hit <= 1'b0;
      temp_lower_hit <= 1'b0;
      temp_irq       <= 1'b0;
    end else begin
      temp_upper_hit <= next_upper_hit;
      temp_lower_hit <= next_lower_hit;
      temp_irq       <= next_upper_hit || next_lower_hit;
    end
  end

  tacl_precharge #(
    .CYC_100 (CYC_100),
    .CYC_101 (CYC_101),
    .CYC_111 (CYC_111)
  ) u_precharge (
    .clock      (clock),
    .rst_n_sync (rst_n_sync),
    .start      (sense_start),
    .powerdown  (pen_detect_powerdown),
    .sel        (precharge_time_sel),
    .active     (precharge_active),
    .done       (precharge_done)
  );

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n_sync);

  soft_reset_a: assert property (
    soft_reset |=> touch_sense_config == `TACL_RST_CONFIG
      && temp_upper_limit == `TACL_RST_UPPER
      && temp_lower_limit == `TACL_RST_LOWER
      && reset_command == `TACL_RST_RESET)
    else $error("reset-all left a register off default");
  limits_init_a: assert property (
    $rose(rst_n_sync) |-> temp_upper_limit_val == 12'hfff
      && temp_lower_limit_val == 12'h000 && !temp_upper_check_en
      && !temp_lower_check_en)
    else $error("limit fields wrong after reset");
  upper_trip_a: assert property (
    conv_valid && conv_is_temp && auto_scan
      && conv_sensor == auto_temp_sensor_select && temp_upper_check_en
      && conv_data >= temp_upper_limit_val |=> temp_upper_hit && temp_irq)
    else $error("upper limit crossing missed");
  lower_trip_a: assert property (
    conv_valid && conv_is_temp && auto_scan
      && conv_sensor == auto_temp_sensor_select && temp_lower_check_en
      && conv_data <= temp_lower_limit_val |=> temp_lower_hit && temp_irq)
    else $error("lower limit crossing missed");
  check_enable_a: assert property (
    !temp_upper_check_en && !temp_lower_check_en |=> !temp_irq)
    else $error("interrupt with both checks disabled");
  temp_only_a: assert property (
    !(conv_valid && conv_is_temp) |=> !temp_upper_hit && !temp_lower_hit)
    else $error("limit event from non-temperature result");
  sensor_pick_a: assert property (
    auto_scan && conv_sensor != auto_temp_sensor_select |=> !temp_irq)
    else $error("unselected sensor raised interrupt");
  pen_pd_a: assert property (
    pen_detect_powerdown |-> !pen_detect_en ##1 !precharge_active)
    else $error("pen detect not powered down");

  soft_reset_c: cover property (soft_reset ##2 reg_rd);
  upper_hit_c:  cover property (temp_upper_hit);
  lower_hit_c:  cover property (temp_lower_hit);
endmodule
`default_nettype wire

// file: verif/tacl_host.sv
// host model: issues word reads and writes on the register port
// assumes the bench calls its tasks and shares the device clock
`timescale 1ns/100ps
`default_nettype none
module tacl_host (
  // clock
  input  wire logic        clock,
  // register port
  output logic      [7:0]  reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 16'h0000;
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    // the reset word only ever receives the reset-all code
    if (a == 8'h04 && d != 16'hbb00) return;
    @(posedge clock) #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clock) #1;
    reg_wr    = 1'b0;
    // released data must not look like the last word
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock) #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clock) #1;
    reg_rd   = 1'b0;
    d        = reg_rdata;
  endtask
endmodule
`default_nettype wire

// file: verif/test_touch_adc_config_temp_limits.sv
// bench for the touch configuration and temperature limit bank
// assumes tacl_host drives the register port; short precharge counts
`timescale 1ns/100ps
`default_nettype none
module test_touch_adc_config_temp_limits;
  logic        clock;
  logic        rstn;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        auto_scan;
  logic        auto_temp_sensor_select;
  logic [3:0]  converter_scan_mode_field;
  logic        conv_valid;
  logic        conv_is_temp;
  logic        conv_sensor;
  logic [11:0] conv_data;
  logic        sense_start;
  logic        precharge_active;
  logic        precharge_done;
  logic        pen_detect_en;
  logic        temp_upper_hit;
  logic        temp_lower_hit;
  logic        temp_irq;
  int          failures;
  int          checks;
  int          lens [8] = '{200, 840, 2760, 3400, 5, 6, 7, 7};

  tacl_regs #(.CYC_100(5), .CYC_101(6), .CYC_111(7)) i_dut (
    .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .auto_scan(auto_scan), .auto_temp_sensor_select(auto_temp_sensor_select),
    .converter_scan_mode_field(converter_scan_mode_field),
    .conv_valid(conv_valid), .conv_is_temp(conv_is_temp),
    .conv_sensor(conv_sensor), .conv_data(conv_data),
    .sense_start(sense_start), .precharge_active(precharge_active),
    .precharge_done(precharge_done), .pen_detect_en(pen_detect_en),
    .temp_upper_hit(temp_upper_hit), .temp_lower_hit(temp_lower_hit),
    .temp_irq(temp_irq));

  tacl_host i_host (
    .clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  always #50 clock = ~clock;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    i_host.rd(a, v);
    check(v, exp);
  endtask

  task automatic pre_run(input logic [2:0] s, input int n);
    int cnt;
    cnt = 0;
    i_host.wr(8'h05, {10'h000, s, 3'b000});
    @(posedge clock) #1;
    sense_start = 1'b1;
    @(posedge clock) #1;
    sense_start = 1'b0;
    while (precharge_active === 1'b1 && cnt < 4000) begin
      cnt++;
      @(posedge clock) #1;
    end
    check(cnt[15:0], n[15:0]);
    check({15'h0, precharge_done}, 16'h0001);
  endtask

  task automatic conv(input logic t, input logic s, input logic [11:0] d,
                      input logic u, input logic l);
    @(posedge clock) #1;
    conv_valid   = 1'b1;
    conv_is_temp = t;
    conv_sensor  = s;
    conv_data    = d;
    @(posedge clock) #1;
    conv_valid   = 1'b0;
    check({14'h0, temp_upper_hit, temp_lower_hit}, {14'h0, u, l});
    check({15'h0, temp_irq}, {15'h0, u | l});
  endtask

  task automatic close_out;
    if (failures == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // watchdog: the whole sequence needs under 9000 cycles
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    close_out();
  end

  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    auto_scan = 1'b1;
    auto_temp_sensor_select = 1'b0;
    converter_scan_mode_field = 4'h0;
    conv_valid = 1'b0;
    conv_is_temp = 1'b0;
    conv_sensor = 1'b0;
    conv_data = 12'h000;
    sense_start = 1'b0;
    failures = 0;
    checks = 0;
    repeat (10) @(posedge clock);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clock);
    for (int pass = 0; pass < 2; pass++) begin
      rdc(8'h04, 16'hffff);
      rdc(8'h05, 16'h0000);
      rdc(8'h06, 16'h0fff);
      rdc(8'h07, 16'h0000);
      rdc(8'h08, 16'h0000);
      check({15'h0, pen_detect_en}, 16'h0001);
      i_host.wr(8'h05, 16'hffff);
      rdc(8'h05, 16'h007f);
      check({15'h0, pen_detect_en}, 16'h0000);
      i_host.wr(8'h06, 16'hffff);
      rdc(8'h06, 16'h1fff);
      i_host.wr(8'h07, 16'hffff);
      rdc(8'h07, 16'h1fff);
      i_host.wr(8'h04, 16'hbb00);
    end
    for (int i = 0; i < 8; i++) pre_run(i[2:0], lens[i]);
    // powerdown mid-interval aborts, then a new start is refused
    i_host.wr(8'h05, 16'h0038);
    @(posedge clock) #1;
    sense_start = 1'b1;
    @(posedge clock) #1;
    sense_start = 1'b0;
    i_host.wr(8'h05, 16'h0078);
    @(posedge clock) #1;
    check({15'h0, precharge_active}, 16'h0000);
    sense_start = 1'b1;
    @(posedge clock) #1;
    sense_start = 1'b0;
    @(posedge clock) #1;
    check({15'h0, precharge_active}, 16'h0000);
    i_host.wr(8'h05, 16'h0000);
    i_host.wr(8'h06, 16'h1800);
    i_host.wr(8'h07, 16'h1100);
    conv(1'b1, 1'b0, 12'h800, 1'b1, 1'b0);
    conv(1'b1, 1'b0, 12'h7ff, 1'b0, 1'b0);
    conv(1'b1, 1'b0, 12'h100, 1'b0, 1'b1);
    conv(1'b1, 1'b0, 12'h101, 1'b0, 1'b0);
    conv(1'b0, 1'b0, 12'hfff, 1'b0, 1'b0);
    conv(1'b1, 1'b1, 12'hfff, 1'b0, 1'b0);
    auto_temp_sensor_select = 1'b1;
    conv(1'b1, 1'b1, 12'h000, 1'b0, 1'b1);
    auto_scan = 1'b0;
    converter_scan_mode_field = 4'h7;
    conv(1'b1, 1'b1, 12'hfff, 1'b1, 1'b0);
    converter_scan_mode_field = 4'h6;
    conv(1'b1, 1'b0, 12'h000, 1'b0, 1'b1);
    converter_scan_mode_field = 4'h5;
    conv(1'b1, 1'b0, 12'hfff, 1'b0, 1'b0);
    converter_scan_mode_field = 4'h6;
    i_host.wr(8'h06, 16'h0800);
    conv(1'b1, 1'b0, 12'hfff, 1'b0, 1'b0);
    i_host.wr(8'h04, 16'hbb00);
    conv(1'b1, 1'b0, 12'h000, 1'b0, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
